// >>> design/tqr_pkg.sv
// constants, carrier types and helpers for torque reference conditioning
// Operation
// - low-pass the analog sample, programmable time constant
// - input filter leaves drift and dead zone alone
// - subtract signed zero drift after filtering
// - subtract signed offset from drift-corrected sample
// - zero the value inside offset plus/minus dead zone
// - scale dead-zone output by full-scale torque setting
// - coarse and fine analog voltage read monitors
// - invert input reverses the set direction
// - direction is xor of setting, sign, invert
// - two torque filters, second only when selected
// - filter cutoffs programmable, defaults 200 and 280
// - clamp magnitude to active limit, keep sign
// - limit stage always applied in every mode
// - one active limit pair, capped at 300 percent and maximum
// - limit source setting picks the active limit
// - source codes internal, external, first, second input
// - external limits only while limit switch active
package tqr_pkg;

  // register byte addresses
  localparam logic [7:0] TQR_FILT_TIME_ADDR = 8'h00;
  localparam logic [7:0] TQR_DRIFT_ADDR = 8'h04;
  localparam logic [7:0] TQR_OFFSET_ADDR = 8'h08;
  localparam logic [7:0] TQR_DEAD_ADDR = 8'h0C;
  localparam logic [7:0] TQR_FULL_SCALE_ADDR = 8'h10;
  localparam logic [7:0] TQR_MON_ADDR = 8'h14;
  localparam logic [7:0] TQR_MON_FINE_ADDR = 8'h18;
  localparam logic [7:0] TQR_CTRL_ADDR = 8'h1C;
  localparam logic [7:0] TQR_CUT1_ADDR = 8'h20;
  localparam logic [7:0] TQR_CUT2_ADDR = 8'h24;
  localparam logic [7:0] TQR_LIM_SRC_ADDR = 8'h28;
  localparam logic [7:0] TQR_INT_POS_ADDR = 8'h2C;
  localparam logic [7:0] TQR_INT_NEG_ADDR = 8'h30;
  localparam logic [7:0] TQR_EXT_FWD_ADDR = 8'h34;
  localparam logic [7:0] TQR_EXT_REV_ADDR = 8'h38;
  localparam logic [7:0] TQR_MAX_TRQ_ADDR = 8'h3C;
  localparam logic [7:0] TQR_STATUS_ADDR = 8'h40;

  // control register fields
  localparam int TQR_CTRL_ROT_BIT = 0;
  localparam int TQR_CTRL_FSEL_BIT = 1;
  localparam int TQR_CTRL_SRC_BIT = 2;
  // status register fields
  localparam int TQR_STAT_LIM_BIT = 0;
  localparam int TQR_STAT_CCW_BIT = 1;

  // reset values
  localparam logic [15:0] TQR_FILT_TIME_RST = 16'h0032;
  localparam logic [15:0] TQR_FULL_SCALE_RST = 16'h03E8;
  localparam logic [15:0] TQR_CUT1_RST = 16'h00C8;
  localparam logic [15:0] TQR_CUT2_RST = 16'h0118;
  localparam logic [15:0] TQR_LIMIT_RST = 16'h0BB8;
  localparam logic [1:0] TQR_LIM_SRC_RST = 2'h0;

  // limit source codes
  localparam logic [1:0] TQR_LIM_INTERNAL = 2'h0;
  localparam logic [1:0] TQR_LIM_EXTERNAL = 2'h1;
  localparam logic [1:0] TQR_LIM_AI_ONE = 2'h2;
  localparam logic [1:0] TQR_LIM_AI_TWO = 2'h3;

  // scaling, samples in 0.1 mV, torque in 0.1 %
  localparam logic signed [47:0] TQR_FULL_SCALE_UV = 48'sh0000_0001_86A0;
  localparam logic signed [47:0] TQR_SAT_POS = 48'sh0000_0001_86A0;
  localparam logic signed [47:0] TQR_SAT_NEG = -48'sh0000_0001_86A0;
  localparam logic signed [47:0] TQR_OFFSET_SCALE = 48'sh0000_0000_000A;
  localparam logic signed [31:0] TQR_MON_DIV = 32'sh0000_0064;
  localparam logic signed [31:0] TQR_MON_MAX = 32'sh0000_04B0;
  localparam logic signed [31:0] TQR_FINE_MUL = 32'sh0000_0064;
  localparam logic [15:0] TQR_ABS_LIMIT = 16'h0BB8;
  localparam logic [15:0] TQR_CUT_MIN = 16'h0005;
  localparam logic [15:0] TQR_CUT_MAX = 16'h3E80;

  // timing of the sample stream
  localparam longint TQR_SAMPLE_PERIOD_NS = 50000;
  localparam longint TQR_FILT_UNIT_NS = 10000;
  localparam int TQR_COEF_FRAC = 16;
  localparam logic [16:0] TQR_COEF_ONE = 17'h1_0000;
  localparam longint TQR_KCUT_Q8 =
    (64'd628318 * TQR_SAMPLE_PERIOD_NS * 64'd16777216) / 64'd100000000000000;

  typedef struct packed {
    logic valid;
    logic signed [31:0] data;
  } tqr_smp_type;

  typedef struct packed {
    logic [15:0] filt_time;
    logic signed [15:0] drift;
    logic signed [15:0] offset;
    logic [15:0] dead;
    logic [15:0] full_scale;
    logic rot_dir;
    logic filt_sel;
    logic ref_src;
    logic [15:0] cut1;
    logic [15:0] cut2;
    logic [1:0] lim_src;
    logic [15:0] int_pos;
    logic [15:0] int_neg;
    logic [15:0] ext_fwd;
    logic [15:0] ext_rev;
    logic [15:0] max_trq;
  } tqr_cfg_type;

  // coefficient from a cutoff in Hz, clamped to the legal range
  function automatic logic [16:0] tqr_coef_cut(input logic [15:0] hz);
    logic [15:0] f;
    logic [63:0] k;
    f = (hz < TQR_CUT_MIN) ? TQR_CUT_MIN : ((hz > TQR_CUT_MAX) ? TQR_CUT_MAX : hz);
    k = (64'(f) * 64'(TQR_KCUT_Q8)) >> 8;
    return (k > 64'(TQR_COEF_ONE)) ? TQR_COEF_ONE : k[16:0];
  endfunction

  // coefficient Ts/(tau+Ts) from a time constant in 0.01 ms steps
  function automatic logic [16:0] tqr_coef_tc(input logic [15:0] steps);
    logic [63:0] den;
    logic [63:0] k;
    den = 64'(steps) * 64'(TQR_FILT_UNIT_NS) + 64'(TQR_SAMPLE_PERIOD_NS);
    k = (64'(TQR_SAMPLE_PERIOD_NS) << TQR_COEF_FRAC) / den;
    return k[16:0];
  endfunction

endpackage

// >>> design/tqr_lpf.sv
// first-order recursive low-pass stage for one sample stream
`timescale 1ns/1ps
module tqr_lpf
  import tqr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stream and coefficient
  input tqr_smp_type x,
  input wire logic [16:0] coef,
  output tqr_smp_type y
);

  typedef struct packed {
    logic signed [47:0] acc;
    tqr_smp_type out;
  } tqr_lpf_st_type;

  tqr_lpf_st_type s_q;
  tqr_lpf_st_type s_d;

  always_comb begin
    logic signed [47:0] diff;
    logic signed [65:0] prod;
    diff = '0;
    prod = '0;
    s_d = s_q;
    s_d.out.valid = 1'b0;
    if (x.valid) begin
      // acc += k * (x - acc), acc in Q16
      diff = {x.data, 16'h0000} - s_q.acc;
      prod = diff * $signed({1'b0, coef});
      s_d.acc = s_q.acc + prod[63:16];
      s_d.out.data = s_d.acc[47:16];
      s_d.out.valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign y = s_q.out;

endmodule

// >>> design/tqr_conditioner.sv
// torque reference conditioning chain with its APB register file
`timescale 1ns/1ps
module tqr_conditioner
  import tqr_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // sample streams
  input tqr_smp_type ANALOG_INPUT_ONE,
  input tqr_smp_type ANALOG_INPUT_TWO,
  input tqr_smp_type TORQUE_DIGITAL_REF,
  // digital inputs
  input wire logic TORQUE_DIRECTION_INVERT_INPUT,
  input wire logic EXTERNAL_LIMIT_SWITCH,
  // conditioned reference
  output tqr_smp_type TORQUE_REF_OUT,
  output logic MOTOR_CCW,
  output logic TORQUE_LIMITED
);

  typedef struct packed {
    tqr_cfg_type cfg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic signed [31:0] mon;
    logic signed [31:0] mon_fine;
    logic signed [31:0] ai_one_trq;
    logic signed [31:0] ai_two_trq;
    tqr_smp_type ref_val;
    logic ccw_pend;
    tqr_smp_type out;
    logic ccw;
    logic limited;
  } tqr_state_type;

  tqr_state_type s_q;
  tqr_state_type s_d;
  tqr_smp_type ai_filt;
  tqr_smp_type trq_f1;
  tqr_smp_type trq_f2;
  logic [16:0] coef_ai;
  logic [16:0] coef_f1;
  logic [16:0] coef_f2;

  // address decode shared by read and write
  function automatic logic tqr_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= TQR_STATUS_ADDR);
  endfunction

  // magnitude cap: 300 percent and the drive/motor maximum
  function automatic logic signed [31:0] tqr_cap(input logic [15:0] v, input logic [15:0] mx);
    logic [15:0] c;
    c = (v > TQR_ABS_LIMIT) ? TQR_ABS_LIMIT : v;
    c = (c > mx) ? mx : c;
    return $signed({16'h0000, c});
  endfunction

  // absolute value of a signed torque
  function automatic logic signed [31:0] tqr_abs(input logic signed [31:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // magnitude of a signed torque, saturated to 16 bits
  function automatic logic [15:0] tqr_mag16(input logic signed [31:0] v);
    logic signed [31:0] m;
    m = tqr_abs(v);
    return (m > 32'sh0000_FFFF) ? 16'hFFFF : m[15:0];
  endfunction

  // saturation and full-scale scaling of one analog sample to a torque value
  function automatic logic signed [31:0] tqr_scale(input logic signed [31:0] v,
                                                   input logic [15:0] fs);
    logic signed [47:0] sat;
    logic signed [63:0] prod;
    sat = 48'(v);
    sat = (sat > TQR_SAT_POS) ? TQR_SAT_POS : ((sat < TQR_SAT_NEG) ? TQR_SAT_NEG : sat);
    prod = 64'(sat) * $signed({48'h0000_0000_0000, fs});
    prod = prod / 64'(TQR_FULL_SCALE_UV);
    return prod[31:0];
  endfunction

  assign coef_ai = tqr_coef_tc(s_q.cfg.filt_time);
  assign coef_f1 = tqr_coef_cut(s_q.cfg.cut1);
  assign coef_f2 = tqr_coef_cut(s_q.cfg.cut2);

  tqr_lpf u_ai_filter (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .x(ANALOG_INPUT_ONE),
    .coef(coef_ai),
    .y(ai_filt)
  );

  tqr_lpf u_trq_filter_one (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .x(s_q.ref_val),
    .coef(coef_f1),
    .y(trq_f1)
  );

  tqr_lpf u_trq_filter_two (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .x(s_q.ref_val),
    .coef(coef_f2),
    .y(trq_f2)
  );

  always_comb begin
    logic signed [47:0] y3;
    logic signed [47:0] y4;
    logic signed [47:0] y5;
    logic signed [47:0] dz;
    logic signed [31:0] raw;
    logic signed [31:0] filt;
    logic signed [31:0] lpos;
    logic signed [31:0] lneg;
    logic signed [31:0] coarse;
    logic flip;
    y3 = '0;
    y4 = '0;
    y5 = '0;
    dz = '0;
    raw = '0;
    filt = '0;
    lpos = '0;
    lneg = '0;
    coarse = '0;
    flip = 1'b0;
    s_d = s_q;

    // APB: one wait state, answer from registers
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (PSEL && PENABLE && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !tqr_hit(PADDR);
      case (PADDR)
        TQR_FILT_TIME_ADDR: s_d.prdata = {16'h0000, s_q.cfg.filt_time};
        TQR_DRIFT_ADDR: s_d.prdata = 32'(s_q.cfg.drift);
        TQR_OFFSET_ADDR: s_d.prdata = 32'(s_q.cfg.offset);
        TQR_DEAD_ADDR: s_d.prdata = {16'h0000, s_q.cfg.dead};
        TQR_FULL_SCALE_ADDR: s_d.prdata = {16'h0000, s_q.cfg.full_scale};
        TQR_MON_ADDR: s_d.prdata = s_q.mon;
        TQR_MON_FINE_ADDR: s_d.prdata = s_q.mon_fine;
        TQR_CTRL_ADDR: s_d.prdata = {29'h0000_0000, s_q.cfg.ref_src, s_q.cfg.filt_sel,
                                     s_q.cfg.rot_dir};
        TQR_CUT1_ADDR: s_d.prdata = {16'h0000, s_q.cfg.cut1};
        TQR_CUT2_ADDR: s_d.prdata = {16'h0000, s_q.cfg.cut2};
        TQR_LIM_SRC_ADDR: s_d.prdata = {30'h0000_0000, s_q.cfg.lim_src};
        TQR_INT_POS_ADDR: s_d.prdata = {16'h0000, s_q.cfg.int_pos};
        TQR_INT_NEG_ADDR: s_d.prdata = {16'h0000, s_q.cfg.int_neg};
        TQR_EXT_FWD_ADDR: s_d.prdata = {16'h0000, s_q.cfg.ext_fwd};
        TQR_EXT_REV_ADDR: s_d.prdata = {16'h0000, s_q.cfg.ext_rev};
        TQR_MAX_TRQ_ADDR: s_d.prdata = {16'h0000, s_q.cfg.max_trq};
        TQR_STATUS_ADDR: s_d.prdata = {30'h0000_0000, s_q.ccw, s_q.limited};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (PSEL && PENABLE && s_q.pready && PWRITE) begin
      case (PADDR)
        TQR_FILT_TIME_ADDR: s_d.cfg.filt_time = PWDATA[15:0];
        TQR_DRIFT_ADDR: s_d.cfg.drift = PWDATA[15:0];
        TQR_OFFSET_ADDR: s_d.cfg.offset = PWDATA[15:0];
        TQR_DEAD_ADDR: s_d.cfg.dead = PWDATA[15:0];
        TQR_FULL_SCALE_ADDR: s_d.cfg.full_scale = PWDATA[15:0];
        TQR_CTRL_ADDR: begin
          s_d.cfg.rot_dir = PWDATA[TQR_CTRL_ROT_BIT];
          s_d.cfg.filt_sel = PWDATA[TQR_CTRL_FSEL_BIT];
          s_d.cfg.ref_src = PWDATA[TQR_CTRL_SRC_BIT];
        end
        TQR_CUT1_ADDR: s_d.cfg.cut1 = PWDATA[15:0];
        TQR_CUT2_ADDR: s_d.cfg.cut2 = PWDATA[15:0];
        TQR_LIM_SRC_ADDR: s_d.cfg.lim_src = PWDATA[1:0];
        TQR_INT_POS_ADDR: s_d.cfg.int_pos = PWDATA[15:0];
        TQR_INT_NEG_ADDR: s_d.cfg.int_neg = PWDATA[15:0];
        TQR_EXT_FWD_ADDR: s_d.cfg.ext_fwd = PWDATA[15:0];
        TQR_EXT_REV_ADDR: s_d.cfg.ext_rev = PWDATA[15:0];
        TQR_MAX_TRQ_ADDR: s_d.cfg.max_trq = PWDATA[15:0];
        default: s_d.cfg = s_q.cfg;
      endcase
    end

    // analog chain on each filtered sample; the filter never sees drift or dead zone
    s_d.ref_val.valid = 1'b0;
    if (ai_filt.valid) begin
      coarse = ai_filt.data / TQR_MON_DIV;
      s_d.mon = (coarse > TQR_MON_MAX) ? TQR_MON_MAX :
                ((coarse < -TQR_MON_MAX) ? -TQR_MON_MAX : coarse);
      s_d.mon_fine = ai_filt.data * TQR_FINE_MUL;
      y3 = 48'(ai_filt.data) - 48'(s_q.cfg.drift);
      y4 = y3 - 48'(s_q.cfg.offset) * TQR_OFFSET_SCALE;
      dz = $signed({32'h0000_0000, s_q.cfg.dead});
      y5 = ((y4 >= -dz) && (y4 <= dz)) ? 48'sh0 : y4;
      y5 = (y5 > TQR_SAT_POS) ? TQR_SAT_POS : ((y5 < TQR_SAT_NEG) ? TQR_SAT_NEG : y5);
      s_d.ai_one_trq = tqr_scale(y5[31:0], s_q.cfg.full_scale);
    end
    if (ANALOG_INPUT_TWO.valid) begin
      s_d.ai_two_trq = tqr_scale(ANALOG_INPUT_TWO.data, s_q.cfg.full_scale);
    end

    // pick the reference, then apply direction
    if (s_q.cfg.ref_src) begin
      raw = s_d.ai_one_trq;
      s_d.ref_val.valid = ai_filt.valid;
    end else begin
      raw = TORQUE_DIGITAL_REF.data;
      s_d.ref_val.valid = TORQUE_DIGITAL_REF.valid;
    end
    if (s_d.ref_val.valid) begin
      flip = s_q.cfg.rot_dir ^ TORQUE_DIRECTION_INVERT_INPUT;
      s_d.ref_val.data = flip ? -raw : raw;
      s_d.ccw_pend = !(s_q.cfg.rot_dir ^ (raw < 0) ^ TORQUE_DIRECTION_INVERT_INPUT);
    end

    // one active limit pair, capped
    case (s_q.cfg.lim_src)
      TQR_LIM_INTERNAL: begin
        lpos = tqr_cap(s_q.cfg.int_pos, s_q.cfg.max_trq);
        lneg = tqr_cap(s_q.cfg.int_neg, s_q.cfg.max_trq);
      end
      TQR_LIM_EXTERNAL: begin
        lpos = tqr_cap(EXTERNAL_LIMIT_SWITCH ? s_q.cfg.ext_fwd : s_q.cfg.int_pos,
                       s_q.cfg.max_trq);
        lneg = tqr_cap(EXTERNAL_LIMIT_SWITCH ? s_q.cfg.ext_rev : s_q.cfg.int_neg,
                       s_q.cfg.max_trq);
      end
      TQR_LIM_AI_ONE: begin
        lpos = tqr_cap(tqr_mag16(s_q.ai_one_trq), s_q.cfg.max_trq);
        lneg = lpos;
      end
      TQR_LIM_AI_TWO: begin
        lpos = tqr_cap(tqr_mag16(s_q.ai_two_trq), s_q.cfg.max_trq);
        lneg = lpos;
      end
      default: begin
        lpos = '0;
        lneg = '0;
      end
    endcase

    // selected filter then mandatory limit
    s_d.out.valid = trq_f1.valid;
    if (trq_f1.valid) begin
      filt = s_q.cfg.filt_sel ? trq_f2.data : trq_f1.data;
      s_d.ccw = s_q.ccw_pend;
      if (filt > lpos) begin
        s_d.out.data = lpos;
        s_d.limited = 1'b1;
      end else if (filt < -lneg) begin
        s_d.out.data = -lneg;
        s_d.limited = 1'b1;
      end else begin
        s_d.out.data = filt;
        s_d.limited = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.cfg.filt_time <= TQR_FILT_TIME_RST;
      s_q.cfg.full_scale <= TQR_FULL_SCALE_RST;
      s_q.cfg.cut1 <= TQR_CUT1_RST;
      s_q.cfg.cut2 <= TQR_CUT2_RST;
      s_q.cfg.lim_src <= TQR_LIM_SRC_RST;
      s_q.cfg.int_pos <= TQR_LIMIT_RST;
      s_q.cfg.int_neg <= TQR_LIMIT_RST;
      s_q.cfg.ext_fwd <= TQR_LIMIT_RST;
      s_q.cfg.ext_rev <= TQR_LIMIT_RST;
      s_q.cfg.max_trq <= TQR_LIMIT_RST;
      s_q.ccw <= 1'b1;
      s_q.ccw_pend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign TORQUE_REF_OUT = s_q.out;
  assign MOTOR_CCW = s_q.ccw;
  assign TORQUE_LIMITED = s_q.limited;

endmodule

// >>> tb/tqr_conditioner_props.sv
// assertion checker for the torque reference conditioner
`timescale 1ns/1ps
module tqr_conditioner_props
  import tqr_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // streams
  input tqr_smp_type ANALOG_INPUT_ONE,
  input tqr_smp_type TORQUE_DIGITAL_REF,
  input tqr_smp_type TORQUE_REF_OUT,
  input wire logic MOTOR_CCW
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  logic bad_addr;
  logic signed [31:0] out_d;
  assign bad_addr = (PADDR > TQR_STATUS_ADDR) || (PADDR[1:0] != 2'h0);
  assign out_d = TORQUE_REF_OUT.data;
  chk_one_wait:
    assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  chk_ready_pulse:
    assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_bad:
    assert property (PREADY && bad_addr |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("bad address not refused");
  chk_err_good:
    assert property (PREADY && !bad_addr |-> !PSLVERR)
    else $error("mapped address refused");
  chk_mon_range:
    assert property (PREADY && !PWRITE && PADDR == TQR_MON_ADDR |->
      $signed(PRDATA) >= -1200 && $signed(PRDATA) <= 1200)
    else $error("coarse monitor out of range");
  chk_abs_cap:
    assert property (TORQUE_REF_OUT.valid |-> out_d <= 3000 && out_d >= -3000)
    else $error("output above absolute cap");
  chk_out_hold:
    assert property (!TORQUE_REF_OUT.valid |-> $stable(out_d) && $stable(MOTOR_CCW))
    else $error("output moved without valid");
  chk_ccw_sign:
    assert property (TORQUE_REF_OUT.valid && out_d != 0 |-> MOTOR_CCW == (out_d > 0))
    else $error("rotation flag disagrees with sign");
  chk_out_cause:
    assert property (TORQUE_REF_OUT.valid |->
      $past(ANALOG_INPUT_ONE.valid, 4) || $past(TORQUE_DIGITAL_REF.valid, 3))
    else $error("output without sample at latency");
endmodule

bind tqr_conditioner tqr_conditioner_props tqr_conditioner_props_inst (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .ANALOG_INPUT_ONE(ANALOG_INPUT_ONE),
  .TORQUE_DIGITAL_REF(TORQUE_DIGITAL_REF), .TORQUE_REF_OUT(TORQUE_REF_OUT),
  .MOTOR_CCW(MOTOR_CCW));

// >>> tb/tqr_host_model.sv
// host controller model driving analog samples and the invert input
`timescale 1ns/1ps
module tqr_host_model
  import tqr_pkg::*;
(
  // clock
  input wire logic clk,
  // samples and direction input
  output tqr_smp_type ai_one,
  output tqr_smp_type ai_two,
  output logic invert
);
  int gap;
  initial begin
    gap = 0;
    ai_one = '0;
    ai_two = '0;
    invert = 1'b0;
  end
  // idle data inverted so a stale sample never looks current
  task automatic send(input logic two, input int v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    if (two) ai_two <= '{1'b1, v};
    else ai_one <= '{1'b1, v};
    @(posedge clk);
    if (two) ai_two <= '{1'b0, ~v};
    else ai_one <= '{1'b0, ~v};
  endtask
  task automatic set_invert(input logic b);
    @(posedge clk);
    invert <= b;
  endtask
endmodule

// >>> tb/tqr_conditioner_bench.sv
// self-checking bench for the torque reference conditioner
`timescale 1ns/1ps
module tqr_conditioner_bench
  import tqr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, ext_sw, invert, ccw, limited, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tqr_smp_type ai_one, ai_two, dig_ref, ref_out;
  int err_total, checks, cyc;

  always #4 clk = ~clk;

  tqr_conditioner tqr_conditioner_inst (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ANALOG_INPUT_ONE(ai_one),
    .ANALOG_INPUT_TWO(ai_two), .TORQUE_DIGITAL_REF(dig_ref),
    .TORQUE_DIRECTION_INVERT_INPUT(invert), .EXTERNAL_LIMIT_SWITCH(ext_sw),
    .TORQUE_REF_OUT(ref_out), .MOTOR_CCW(ccw), .TORQUE_LIMITED(limited));
  tqr_host_model tqr_host_model_inst (.clk(clk), .ai_one(ai_one), .ai_two(ai_two),
    .invert(invert));

  task automatic complete_run();
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  // source 0 digital, 1 first analog, 2 second analog
  task automatic send(input int src, input int v);
    if (src == 0) begin
      @(posedge clk);
      dig_ref <= '{1'b1, v};
      @(posedge clk);
      dig_ref <= '{1'b0, ~v};
    end else begin
      tqr_host_model_inst.send(src == 2, v);
    end
  endtask
  task automatic take(input int lat, input int exp);
    repeat (lat - 1) @(posedge clk);
    @(negedge clk);
    chk("out valid", 32'(ref_out.valid), 32'h0000_0001);
    chk("out data", ref_out.data, exp);
  endtask
  // unity filters, no corrections, nominal full scale
  task automatic cfg_pass(input logic [31:0] ctrl);
    wr(TQR_FILT_TIME_ADDR, 32'h0000_0000);
    wr(TQR_CUT1_ADDR, 32'h0000_3E80);
    wr(TQR_CUT2_ADDR, 32'h0000_4E20);
    wr(TQR_DRIFT_ADDR, 32'h0000_0000);
    wr(TQR_OFFSET_ADDR, 32'h0000_0000);
    wr(TQR_DEAD_ADDR, 32'h0000_0000);
    wr(TQR_FULL_SCALE_ADDR, 32'h0000_03E8);
    wr(TQR_CTRL_ADDR, ctrl);
  endtask

  task automatic t_reset();
    logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h38,
      8'h3C, 8'h14};
    int rv[10] = '{50, 0, 1000, 200, 280, 0, 3000, 3000, 3000, 0};
    for (int i = 0; i < 10; i++) rchk(ra[i], rv[i], "reset value");
    apb(1'b0, 8'h44, 32'h0000_0000);
    chk("unmapped error", 32'(er), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, 8'h06, 32'h0000_1234);
    chk("unaligned error", 32'(er), 32'h0000_0001);
    wr(TQR_MON_ADDR, 32'h0000_0123);
    rchk(TQR_MON_ADDR, 32'h0000_0000, "monitor write");
  endtask

  task automatic t_analog();
    int xin[6] = '{60000, 16000, 16001, -2000, 150000, 13000};
    int yout[6] = '{520, 0, 80, -100, 1000, 0};
    cfg_pass(32'h0000_0004);
    wr(TQR_DRIFT_ADDR, 32'h0000_0FA0);
    wr(TQR_OFFSET_ADDR, 32'h0000_0190);
    wr(TQR_DEAD_ADDR, 32'h0000_1F40);
    for (int i = 0; i < 6; i++) begin
      send(1, xin[i]);
      take(4, yout[i]);
    end
    wr(TQR_FULL_SCALE_ADDR, 32'h0000_09C4);
    send(1, 60000);
    take(4, 1300);
    rchk(TQR_MON_ADDR, 600, "coarse monitor");
    rchk(TQR_MON_FINE_ADDR, 6000000, "fine monitor");
    send(1, -130000);
    take(4, -2500);
    rchk(TQR_MON_ADDR, -1200, "coarse clamp");
    send(1, 0);
    repeat (6) @(posedge clk);
    wr(TQR_FILT_TIME_ADDR, 32'h0000_0032);
    send(1, 60000);
    repeat (6) @(posedge clk);
    apb(1'b0, TQR_MON_ADDR, 32'h0000_0000);
    chk("input filter", 32'($signed(rd) > 0 && $signed(rd) < 600), 32'h0000_0001);
  endtask

  task automatic t_dir();
    int r;
    cfg_pass(32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      r = i[1] ? -500 : 500;
      wr(TQR_CTRL_ADDR, 32'(i[2]));
      tqr_host_model_inst.set_invert(i[0]);
      send(0, r);
      take(3, (i[2] ^ i[0]) ? -r : r);
      chk("rotation", 32'(ccw), 32'(!(i[2] ^ i[1] ^ i[0])));
    end
    tqr_host_model_inst.set_invert(1'b0);
  endtask

  task automatic t_filter();
    cfg_pass(32'h0000_0000);
    send(0, 0);
    take(3, 0);
    wr(TQR_CUT1_ADDR, 32'h0000_0003);
    rchk(TQR_CUT1_ADDR, 32'h0000_0003, "raw cutoff");
    send(0, 1000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("first filter", 32'(ref_out.data >= 0 && ref_out.data < 20), 32'h0000_0001);
    wr(TQR_CTRL_ADDR, 32'h0000_0002);
    send(0, 1000);
    take(3, 1000);
  endtask

  task automatic t_limit();
    int src[9] = '{0, 0, 0, 1, 1, 1, 2, 2, 3};
    int tin[9] = '{2000, -2000, 999, 2000, -2000, 2000, -2000, 200, 2000};
    int tout[9] = '{1000, -800, 999, 600, -700, 1000, -300, 200, 500};
    logic [8:0] swm = 9'b0_0001_1000;
    cfg_pass(32'h0000_0000);
    wr(TQR_INT_POS_ADDR, 32'h0000_03E8);
    wr(TQR_INT_NEG_ADDR, 32'h0000_0320);
    wr(TQR_EXT_FWD_ADDR, 32'h0000_0258);
    wr(TQR_EXT_REV_ADDR, 32'h0000_02BC);
    tqr_host_model_inst.gap = 5;
    send(1, 30000);
    send(2, 50000);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      wr(TQR_LIM_SRC_ADDR, 32'(src[i]));
      @(posedge clk);
      ext_sw <= swm[i];
      send(0, tin[i]);
      take(3, tout[i]);
      chk("limited flag", 32'(limited), 32'(tin[i] != tout[i]));
    end
    wr(TQR_INT_POS_ADDR, 32'h0000_0FA0);
    wr(TQR_LIM_SRC_ADDR, 32'h0000_0000);
    send(0, 3500);
    take(3, 3000);
    wr(TQR_MAX_TRQ_ADDR, 32'h0000_01F4);
    send(0, -2000);
    take(3, -500);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    dig_ref = '0;
    ext_sw = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("ccw in reset", 32'(ccw), 32'h0000_0001);
    chk("out in reset", 32'(ref_out.valid), 32'h0000_0000);
    @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_analog();
    t_dir();
    t_filter();
    t_limit();
    complete_run();
  end

  initial cyc = 0;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
endmodule
